/* File: hdl/pdf_pkg.sv */
// constants, types and decoders shared by the data validity failsafe block
package pdf_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int N_IF        = 3;
  localparam int IF_SHIFT    = 0;
  localparam int IF_FIELDBUS = 1;
  localparam int IF_SERIAL   = 2;
  localparam int DATA_W      = 16;

  localparam logic [15:0] ADDR_IN_COUNT   = 16'h001f;
  localparam logic [15:0] ADDR_MOD_TYPE   = 16'h0020;
  localparam logic [15:0] ADDR_FS_CFG     = 16'h0021;
  localparam logic [15:0] ADDR_SHIFT_VAL  = 16'h0022;
  localparam logic [15:0] ADDR_SERIAL_VAL = 16'h0023;
  localparam logic [15:0] ADDR_FB_VAL     = 16'h0024;
  localparam logic [15:0] ADDR_CHAIN_CFG  = 16'h0025;

  localparam int         FS_FIELD_W    = 2;
  localparam logic [7:0] FS_CFG_MASK   = 8'h3f;
  localparam logic [7:0] FS_CFG_RST    = 8'h00;
  localparam logic [7:0] VAL_RST       = 8'h00;
  localparam logic [7:0] CHAIN_CFG_RST = 8'h03;
  localparam logic [7:0] CHAIN_CFG_MASK = 8'h07;
  localparam int         CHAIN_LED_BIT = 0;
  localparam int         CHAIN_IN_LSB  = 1;
  localparam logic [5:0] CHAIN_MAX     = 6'h20;

  localparam logic [1:0] LOSS_ZERO = 2'h0;
  localparam logic [1:0] LOSS_ONE  = 2'h1;
  localparam logic [1:0] LOSS_HOLD = 2'h2;

  // arbitrary neutral identification value
  localparam logic [7:0] MODULE_TYPE_DFLT = 8'h5a;

  typedef enum logic [2:0] {
    TMR_OFF  = 3'b001,
    TMR_RUN  = 3'b010,
    TMR_LOST = 3'b100
  } pdf_tmr_t;

  // loss behaviour field of one interface, fields packed from bit 0 upward
  function automatic logic [1:0] pdf_loss_field(input logic [7:0] cfg, input int idx);
    return cfg[FS_FIELD_W*idx +: FS_FIELD_W];
  endfunction

  // input chain registers held back for switches; code 11 reserves none
  function automatic logic [1:0] pdf_in_rsvd(input logic [1:0] code);
    return (code == 2'h1) ? 2'h1 : (code == 2'h2) ? 2'h3 : 2'h0;
  endfunction
endpackage

/* File: hdl/pdf_valid_timer.sv */
// validity period timer of one input interface
`timescale 1ns/10ps
`default_nettype none
module pdf_valid_timer
  import pdf_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic [7:0] period,
  input  wire logic       restart,
  output var  logic       lost
);
  localparam logic [31:0] SUB_LAST = 32'(MS_CYC - 1);

  pdf_tmr_t    state, next_state;
  logic [31:0] sub, next_sub;
  logic [7:0]  ms, next_ms;
  logic [7:0]  period_q;
  logic [31:0] elapsed, next_elapsed;
  logic [31:0] limit;
  logic        change;

  // a new period setting restarts the count so the timeout is exact
  assign change = (period != period_q);
  assign lost   = state[2];
  assign limit  = 32'(period_q) * 32'(MS_CYC);

  always_comb begin
    next_state = state;
    next_sub   = sub;
    next_ms    = ms;
    // helper count for the checks below, saturating so it never wraps
    next_elapsed = (restart || change) ? '0 : (&elapsed) ? elapsed : elapsed + 32'h1;
    if (restart || change) begin
      next_sub   = '0;
      next_ms    = '0;
      next_state = (period == 8'h00) ? TMR_OFF : TMR_RUN;
    end else begin
      unique case (state)
        TMR_OFF: begin
        end
        TMR_RUN: begin
          if (sub == SUB_LAST) begin
            next_sub = '0;
            if (ms + 8'h01 >= period_q) begin
              next_state = TMR_LOST;
            end else begin
              next_ms = ms + 8'h01;
            end
          end else begin
            next_sub = sub + 32'h1;
          end
        end
        TMR_LOST: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state    <= TMR_OFF;
      sub      <= '0;
      ms       <= '0;
      period_q <= VAL_RST;
      elapsed  <= '0;
    end else begin
      state    <= next_state;
      sub      <= next_sub;
      ms       <= next_ms;
      period_q <= period;
      elapsed  <= next_elapsed;
    end
  end

  not_early_a: assert property (@(posedge clock) disable iff (!arst_n)
    (elapsed < limit) |-> !lost)
    else $error("interface flagged invalid before its period ran out");

  expire_a: assert property (@(posedge clock) disable iff (!arst_n)
    (period_q != 8'h00 && elapsed == limit && elapsed != 32'h0) |-> lost)
    else $error("interface not flagged invalid at period expiry");

  disabled_a: assert property (@(posedge clock) disable iff (!arst_n)
    (period == 8'h00) |=> !lost)
    else $error("unsupervised interface flagged invalid");

  fresh_a: assert property (@(posedge clock) disable iff (!arst_n)
    restart |=> !lost ##1 (!lost || !$past(restart)))
    else $error("fresh data did not clear the invalid flag");
endmodule
`default_nettype wire

/* File: hdl/pdf_safe_out.sv */
// routed output word of one interface with its safe value on data loss
`timescale 1ns/10ps
`default_nettype none
module pdf_safe_out
  import pdf_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic              prod,
  input  wire logic [DATA_W-1:0] prod_data,
  input  wire logic              lost,
  input  wire logic [1:0]        mode,
  output var  logic [DATA_W-1:0] out_data
);
  logic [DATA_W-1:0] last, next_last;
  logic [DATA_W-1:0] next_out;

  always_comb begin
    next_last = prod ? prod_data : last;
    next_out  = next_last;
    if (lost) begin
      unique case (mode)
        LOSS_ONE:  next_out = '1;
        LOSS_HOLD: next_out = last;
        default:   next_out = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      last     <= '0;
      out_data <= '0;
    end else begin
      last     <= next_last;
      out_data <= next_out;
    end
  end

  safe_zero_a: assert property (@(posedge clock) disable iff (!arst_n)
    (lost && mode == LOSS_ZERO) |=> (out_data == '0))
    else $error("lost interface output not forced to zero");

  safe_one_a: assert property (@(posedge clock) disable iff (!arst_n)
    (lost && mode == LOSS_ONE) |=> (out_data == '1))
    else $error("lost interface output not forced to ones");

  safe_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    (lost && mode == LOSS_HOLD) |=> (out_data == $past(last)))
    else $error("lost interface output did not keep last data");
endmodule
`default_nettype wire

/* File: hdl/pdf_failsafe.sv */
// process data validity failsafe: registers, timers and safe outputs
`timescale 1ns/10ps
`default_nettype none
module pdf_failsafe
  import pdf_pkg::*;
#(
  parameter int         MS_CYC      = MS_CYCLES,
  parameter logic [7:0] MODULE_TYPE = MODULE_TYPE_DFLT
) (
  input  wire logic                         clock,
  input  wire logic                         arst_n,
  input  wire logic [15:0]                  reg_addr,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic [15:0]                  reg_wdata,
  output var  logic [15:0]                  reg_rdata,
  output var  logic                         reg_rvalid,
  output var  logic                         reg_err,
  input  wire logic [N_IF-1:0]              prod,
  input  wire logic [N_IF-1:0][DATA_W-1:0]  prod_data,
  input  wire logic [5:0]                   chain_in_count,
  output var  logic [N_IF-1:0][DATA_W-1:0]  out_data,
  output var  logic [N_IF-1:0]              data_lost,
  output var  logic                         led_reg_rsvd,
  output var  logic [1:0]                   sw_reg_rsvd
);
  localparam int REG_LAT = 1;
  localparam int CFG_LAT = 2;

  // register file state
  logic [7:0]  fs_cfg, next_fs_cfg;
  logic [7:0]  val_ms      [N_IF];
  logic [7:0]  next_val_ms [N_IF];
  logic [7:0]  chain_cfg, next_chain_cfg;
  logic [15:0] next_rdata;
  logic        next_rvalid;
  logic        next_err;

  // status captured from the chain logic
  logic [5:0]  in_count, next_in_count;

  // chain assignment outputs
  logic        next_led;
  logic [1:0]  next_sw;

  // per interface loss code
  logic [1:0]  loss_mode [N_IF];

  // register writes and reads; a write wins if both strobes come together
  always_comb begin
    next_fs_cfg    = fs_cfg;
    next_val_ms    = val_ms;
    next_chain_cfg = chain_cfg;
    next_rdata     = reg_rdata;
    next_rvalid    = 1'b0;
    next_err       = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_FS_CFG: begin
          next_fs_cfg = reg_wdata[7:0] & FS_CFG_MASK;
        end
        ADDR_SHIFT_VAL: begin
          next_val_ms[IF_SHIFT] = reg_wdata[7:0];
        end
        ADDR_SERIAL_VAL: begin
          next_val_ms[IF_SERIAL] = reg_wdata[7:0];
        end
        ADDR_FB_VAL: begin
          next_val_ms[IF_FIELDBUS] = reg_wdata[7:0];
        end
        ADDR_CHAIN_CFG: begin
          next_chain_cfg = reg_wdata[7:0] & CHAIN_CFG_MASK;
        end
        default: begin
          // read-only or unmapped: nothing stored
          next_err = 1'b1;
        end
      endcase
    end else if (reg_rd) begin
      next_rvalid = 1'b1;
      case (reg_addr)
        ADDR_IN_COUNT: begin
          next_rdata = {10'h000, in_count};
        end
        ADDR_MOD_TYPE: begin
          next_rdata = {8'h00, MODULE_TYPE};
        end
        ADDR_FS_CFG: begin
          next_rdata = {8'h00, fs_cfg};
        end
        ADDR_SHIFT_VAL: begin
          next_rdata = {8'h00, val_ms[IF_SHIFT]};
        end
        ADDR_SERIAL_VAL: begin
          next_rdata = {8'h00, val_ms[IF_SERIAL]};
        end
        ADDR_FB_VAL: begin
          next_rdata = {8'h00, val_ms[IF_FIELDBUS]};
        end
        ADDR_CHAIN_CFG: begin
          next_rdata = {8'h00, chain_cfg};
        end
        default: begin
          next_rdata = 16'h0000;
          next_err   = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fs_cfg     <= FS_CFG_RST;
      val_ms     <= '{default: VAL_RST};
      chain_cfg  <= CHAIN_CFG_RST;
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
      reg_err    <= 1'b0;
    end else begin
      fs_cfg     <= next_fs_cfg;
      val_ms     <= next_val_ms;
      chain_cfg  <= next_chain_cfg;
      reg_rdata  <= next_rdata;
      reg_rvalid <= next_rvalid;
      reg_err    <= next_err;
    end
  end

  // the chain logic may report more modules than the register can name
  always_comb begin
    next_in_count = (chain_in_count > CHAIN_MAX) ? CHAIN_MAX : chain_in_count;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      in_count <= 6'h00;
    end else begin
      in_count <= next_in_count;
    end
  end

  // chain assignment, applied one cycle after the register changes
  always_comb begin
    next_led = chain_cfg[CHAIN_LED_BIT];
    next_sw  = pdf_in_rsvd(chain_cfg[CHAIN_IN_LSB +: 2]);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      led_reg_rsvd <= 1'b0;
      sw_reg_rsvd  <= 2'h0;
    end else begin
      led_reg_rsvd <= next_led;
      sw_reg_rsvd  <= next_sw;
    end
  end

  // one timer and one safe output per interface
  for (genvar i = 0; i < N_IF; i++) begin : g_if
    assign loss_mode[i] = pdf_loss_field(fs_cfg, i);

    pdf_valid_timer #(
      .MS_CYC (MS_CYC)
    ) u_timer (
      .clock   (clock),
      .arst_n  (arst_n),
      .period  (val_ms[i]),
      .restart (prod[i]),
      .lost    (data_lost[i])
    );

    pdf_safe_out u_out (
      .clock     (clock),
      .arst_n    (arst_n),
      .prod      (prod[i]),
      .prod_data (prod_data[i]),
      .lost      (data_lost[i]),
      .mode      (loss_mode[i]),
      .out_data  (out_data[i])
    );
  end

  shift_field_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_wr && reg_addr == ADDR_FS_CFG)
      |-> ##REG_LAT (loss_mode[IF_SHIFT] == $past(reg_wdata[1:0])))
    else $error("shift interface loss code not taken from bits 1..0");

  fb_field_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_wr && reg_addr == ADDR_FS_CFG)
      |-> ##REG_LAT (loss_mode[IF_FIELDBUS] == $past(reg_wdata[3:2])))
    else $error("fieldbus loss code not taken from bits 3..2");

  serial_field_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_wr && reg_addr == ADDR_FS_CFG)
      |-> ##REG_LAT (loss_mode[IF_SERIAL] == $past(reg_wdata[5:4]) && fs_cfg[7:6] == 2'h0))
    else $error("serial interface loss code not taken from bits 5..4");

  period_map_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_wr && reg_addr == ADDR_SERIAL_VAL)
      |=> (val_ms[IF_SERIAL] == $past(reg_wdata[7:0]))
        && $stable(val_ms[IF_SHIFT]) && $stable(val_ms[IF_FIELDBUS]))
    else $error("serial period write did not land in its own setting");

  count_clamp_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_rd && !reg_wr && reg_addr == ADDR_IN_COUNT)
      |=> reg_rvalid && !reg_err && reg_rdata <= {10'h000, CHAIN_MAX})
    else $error("input chain count read out of range");

  type_read_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_rd && !reg_wr && reg_addr == ADDR_MOD_TYPE)
      |=> reg_rvalid && reg_rdata == {8'h00, MODULE_TYPE})
    else $error("module type read returned a wrong code");

  type_ro_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_wr && reg_addr == ADDR_MOD_TYPE) |=> reg_err && $stable(fs_cfg))
    else $error("write to module type not refused");

  all_data_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_wr && reg_addr == ADDR_CHAIN_CFG && reg_wdata[2:0] == 3'h0)
      |-> ##CFG_LAT (!led_reg_rsvd && sw_reg_rsvd == 2'h0))
    else $error("chain registers still reserved with assignment cleared");

  led_assign_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_wr && reg_addr == ADDR_CHAIN_CFG)
      |-> ##CFG_LAT (led_reg_rsvd == $past(reg_wdata[0], 2)))
    else $error("lamp register assignment does not follow bit 0");

  sw_assign_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_wr && reg_addr == ADDR_CHAIN_CFG && reg_wdata[2:1] == 2'h2)
      |-> ##CFG_LAT (sw_reg_rsvd == 2'h3))
    else $error("code 10 did not reserve input registers 0 and 1");

  fresh_out_a: assert property (@(posedge clock) disable iff (!arst_n)
    (prod[IF_SHIFT] && !data_lost[IF_SHIFT])
      |=> (out_data[IF_SHIFT] == $past(prod_data[IF_SHIFT])))
    else $error("valid production not passed to the output");

  shift_period_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_wr && reg_addr == ADDR_SHIFT_VAL)
      |=> (val_ms[IF_SHIFT] == $past(reg_wdata[7:0]))
        && $stable(val_ms[IF_SERIAL]) && $stable(val_ms[IF_FIELDBUS]))
    else $error("shift period write did not land in its own setting");

  fb_period_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_wr && reg_addr == ADDR_FB_VAL)
      |=> (val_ms[IF_FIELDBUS] == $past(reg_wdata[7:0]))
        && $stable(val_ms[IF_SHIFT]) && $stable(val_ms[IF_SERIAL]))
    else $error("fieldbus period write did not land in its own setting");

  chain_mask_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_wr && reg_addr == ADDR_CHAIN_CFG)
      |=> (chain_cfg == ($past(reg_wdata[7:0]) & CHAIN_CFG_MASK)))
    else $error("chain assignment not stored as written");

  count_sat_a: assert property (@(posedge clock) disable iff (!arst_n)
    (chain_in_count > CHAIN_MAX)
      |=> (in_count == CHAIN_MAX))
    else $error("input chain count not held at its upper limit");

  count_read_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_rd && !reg_wr && reg_addr == ADDR_IN_COUNT)
      |=> (reg_rdata == {10'h000, $past(in_count)}))
    else $error("input chain count read does not match the count");

  count_ro_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_wr && reg_addr == ADDR_IN_COUNT)
      |=> reg_err && !reg_rvalid && $stable(chain_cfg) && $stable(fs_cfg))
    else $error("write to input chain count not refused");

  sw_one_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_wr && reg_addr == ADDR_CHAIN_CFG && reg_wdata[2:1] == 2'h1)
      |-> ##CFG_LAT (sw_reg_rsvd == 2'h1))
    else $error("code 01 did not reserve input register 0 alone");

  sw_none_a: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_wr && reg_addr == ADDR_CHAIN_CFG && reg_wdata[2:1] == 2'h0)
      |-> ##CFG_LAT (sw_reg_rsvd == 2'h0))
    else $error("code 00 still reserves an input register");

  // each interface's safe value must follow its own field, not a neighbour's
  for (genvar j = 0; j < N_IF; j++) begin : g_chk
    route_ones_a: assert property (@(posedge clock) disable iff (!arst_n)
      (data_lost[j] && loss_mode[j] == LOSS_ONE) |=> (out_data[j] == '1))
      else $error("safe ones not routed to the lost interface");

    route_zero_a: assert property (@(posedge clock) disable iff (!arst_n)
      (data_lost[j] && loss_mode[j] == LOSS_ZERO) |=> (out_data[j] == '0))
      else $error("safe zeros not routed to the lost interface");

    // a mode change while lost may move the word once, so only a steady mode counts
    route_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
      (data_lost[j] && loss_mode[j] == LOSS_HOLD && $stable(loss_mode[j]))
        |=> $stable(out_data[j]))
      else $error("held output word moved while data was lost");
  end
endmodule
`default_nettype wire

/* File: tb/pdf_host_feed.sv */
// far-side model: periodic data producers on the three input interfaces
`timescale 1ns/10ps
`default_nettype none
module pdf_host_feed
  import pdf_pkg::*;
#(
  parameter int GAP = 5
) (
  input  wire logic                        clock,
  input  wire logic [N_IF-1:0]             run,
  output var  logic [N_IF-1:0]             prod,
  output var  logic [N_IF-1:0][DATA_W-1:0] prod_data
);
  int unsigned       tick = 0;
  logic [DATA_W-1:0] seq  = 16'h0100;

  initial begin
    prod      = '0;
    prod_data = '0;
  end

  // between productions the data lines wander so a stale capture cannot pass
  always @(negedge clock) begin
    tick <= (tick == GAP - 1) ? 0 : tick + 1;
    seq  <= seq + 16'h0001;
    for (int i = 0; i < N_IF; i++) begin
      prod[i]      <= run[i] && (tick == 0);
      prod_data[i] <= (run[i] && tick == 0) ? seq ^ (16'(i) << 12) : ~seq;
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench of the data validity failsafe block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pdf_pkg::*;
  localparam int M = 10;
  localparam int P = 2;

  logic                        clock, arst_n, reg_wr, reg_rd, reg_rvalid, reg_err, led_reg_rsvd;
  logic [15:0]                 reg_addr, reg_wdata, reg_rdata;
  logic [N_IF-1:0]             prod, data_lost, run;
  logic [N_IF-1:0][DATA_W-1:0] prod_data, out_data, last;
  logic [5:0]                  chain_in_count;
  logic [1:0]                  sw_reg_rsvd;
  logic [15:0]                 exp_w;
  int                          miscompares = 0;
  int                          n_tests = 0;
  int                          since[N_IF];
  int                          k;

  pdf_failsafe #(.MS_CYC(M)) dut (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_err(reg_err), .prod(prod), .prod_data(prod_data),
    .chain_in_count(chain_in_count), .out_data(out_data), .data_lost(data_lost),
    .led_reg_rsvd(led_reg_rsvd), .sw_reg_rsvd(sw_reg_rsvd));

  pdf_host_feed #(.GAP(5)) feed (.clock(clock), .run(run), .prod(prod), .prod_data(prod_data));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // cycles since the last production and the data it carried
  always @(posedge clock) begin
    for (int i = 0; i < N_IF; i++) begin
      since[i] <= prod[i] ? 0 : since[i] + 1;
      last[i]  <= prod[i] ? prod_data[i] : last[i];
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic err_exp);
    @(negedge clock);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    chk({15'h0000, reg_err}, {15'h0000, err_exp}, "write refusal flag");
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic err_exp);
    @(negedge clock);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    chk({14'h0000, reg_rvalid, reg_err}, {14'h0000, 1'b1, err_exp}, "read answer flags");
    chk(reg_rdata, exp, "read data");
  endtask

  function automatic logic [15:0] period_addr(input int i);
    return (i == IF_SHIFT) ? ADDR_SHIFT_VAL : (i == IF_FIELDBUS) ? ADDR_FB_VAL : ADDR_SERIAL_VAL;
  endfunction

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    arst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0; reg_wdata = '0;
    run = '0; chain_in_count = '0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    @(negedge clock);
    rd(ADDR_FS_CFG, 16'h0000, 1'b0);
    rd(ADDR_SHIFT_VAL, 16'h0000, 1'b0);
    rd(ADDR_SERIAL_VAL, 16'h0000, 1'b0);
    rd(ADDR_FB_VAL, 16'h0000, 1'b0);
    rd(ADDR_CHAIN_CFG, 16'h0003, 1'b0);
    rd(ADDR_MOD_TYPE, {8'h00, MODULE_TYPE_DFLT}, 1'b0);
    chk({13'h0000, led_reg_rsvd, sw_reg_rsvd}, 16'h0005, "chain reset use");
    $display("test reset_values done");

    wr(ADDR_MOD_TYPE, 16'h0011, 1'b1);
    rd(ADDR_MOD_TYPE, {8'h00, MODULE_TYPE_DFLT}, 1'b0);
    wr(ADDR_IN_COUNT, 16'h0007, 1'b1);
    wr(16'h0030, 16'h0001, 1'b1);
    rd(16'h0030, 16'h0000, 1'b1);
    wr(ADDR_FS_CFG, 16'hffff, 1'b0);
    rd(ADDR_FS_CFG, 16'h003f, 1'b0);
    foreach (since[v]) begin
      chain_in_count = (v == 0) ? 6'h00 : (v == 1) ? 6'h20 : 6'h28;
      repeat (2) @(negedge clock);
      rd(ADDR_IN_COUNT, 16'h0020 & {10'h000, chain_in_count}, 1'b0);
    end
    chain_in_count = 6'h11;
    repeat (2) @(negedge clock);
    rd(ADDR_IN_COUNT, 16'h0011, 1'b0);
    $display("test register_access done");

    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CHAIN_CFG, 16'(c), 1'b0);
      repeat (2) @(negedge clock);
      exp_w = {13'h0000, c[0], (c[2:1] == 2'h2) ? 2'h3 : (c[2:1] == 2'h1) ? 2'h1 : 2'h0};
      chk({13'h0000, led_reg_rsvd, sw_reg_rsvd}, exp_w, "chain use");
    end
    $display("test chain_assign done");

    for (int i = 0; i < N_IF; i++) begin
      for (int code = 0; code < 4; code++) begin
        run[i] <= 1'b1;
        wr(ADDR_FS_CFG, 16'(code << (2 * i)), 1'b0);
        wr(period_addr(i), 16'(P), 1'b0);
        k = 0;
        repeat (3 * P * M) begin
          @(negedge clock);
          k += int'(data_lost != '0);
        end
        chk(16'(k), 16'h0000, "loss while producing");
        run[i] <= 1'b0;
        for (k = 0; k < P * M + 10 && data_lost[i] !== 1'b1; k++) @(negedge clock);
        chk({13'h0000, data_lost}, 16'(1 << i), "loss flags");
        chk(16'(since[i] >= P * M - 1 && since[i] <= P * M + 2), 16'h0001, "timeout span");
        repeat (2) @(negedge clock);
        exp_w = (code == 1) ? 16'hffff : (code == 2) ? last[i] : 16'h0000;
        chk(out_data[i], exp_w, "safe value");
        run[i] <= 1'b1;
        for (k = 0; k < 20 && data_lost[i] !== 1'b0; k++) @(negedge clock);
        repeat (2) @(negedge clock);
        chk({15'h0000, data_lost[i]}, 16'h0000, "loss cleared");
        chk(out_data[i], last[i], "fresh data");
        wr(period_addr(i), 16'h0000, 1'b0);
      end
      run[i] <= 1'b0;
    end
    $display("test timeouts done");

    // a lost interface must recover as soon as supervision is switched off
    wr(ADDR_SHIFT_VAL, 16'(P), 1'b0);
    for (k = 0; k < P * M + 10 && data_lost[IF_SHIFT] !== 1'b1; k++) @(negedge clock);
    chk({13'h0000, data_lost}, 16'h0001, "loss before disable");
    wr(ADDR_SHIFT_VAL, 16'h0000, 1'b0);
    repeat (2) @(negedge clock);
    chk({13'h0000, data_lost}, 16'h0000, "loss after disable");
    k = 0;
    repeat (3 * P * M) begin
      @(negedge clock);
      k += int'(data_lost != '0);
    end
    chk(16'(k), 16'h0000, "unsupervised loss");
    $display("test no_supervision done");
    complete_run();
  end
endmodule
`default_nettype wire
